// ---- rtl/seep_pkg.sv ----
// Shared constants and types of the serial EEPROM slave port
package seep_pkg;

   // ****************************************
   // Instruction opcodes
   // ****************************************
   localparam logic [7:0] OP_WREN      = 8'h06;
   localparam logic [7:0] OP_WRDI      = 8'h04;
   localparam logic [7:0] OP_STAT_READ = 8'h05;
   localparam logic [7:0] OP_WRSR      = 8'h01;
   // Array read/write: bit 3 carries address bit 8
   localparam logic [7:0] OP_READ_MASK = 8'hF7;
   localparam logic [7:0] OP_READ      = 8'h03;
   localparam logic [7:0] OP_WRITE     = 8'h02;

   // ****************************************
   // Geometry and status layout
   // ****************************************
   localparam int          ADDR_W       = 9;
   localparam int          MEM_DEPTH    = 512;
   localparam int          PAGE_BYTES   = 16;
   localparam int          PAGE_W       = 4;
   localparam logic [3:0]  STAT_FIXED   = 4'hF;
   localparam int          STAT_RDY_POS = 0;
   localparam int          STAT_WEL_POS = 1;
   localparam int          STAT_BP_LO   = 2;
   localparam int          STAT_BP_HI   = 3;
   localparam logic [7:0]  STAT_BUSY    = 8'hFF;
   localparam logic [1:0]  BP_RESET     = 2'h0;
   localparam logic [8:0]  QUARTER_BASE = 9'h180;
   localparam logic [8:0]  HALF_BASE    = 9'h100;

   // ****************************************
   // Timing
   // ****************************************
   localparam int WRITE_TIME_MS = 5;
   localparam int SYS_CLK_KHZ   = 100000;
   // Longest time: exact product, no rounding
   localparam int WRITE_CYCLES  = WRITE_TIME_MS * SYS_CLK_KHZ;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {
      PH_CMD  = 2'b00,
      PH_ADDR = 2'b01,
      PH_DATA = 2'b11,
      PH_IGN  = 2'b10
   } seep_phase_t;

   typedef enum logic [2:0] {
      CK_NONE  = 3'h0,
      CK_WREN  = 3'h1,
      CK_WRDI  = 3'h2,
      CK_WRSR  = 3'h3,
      CK_WRITE = 3'h4,
      CK_READ  = 3'h5,
      CK_STAT  = 3'h6
   } seep_kind_t;

endpackage : seep_pkg

// ---- rtl/seep_sync.sv ----
// Two-flop level synchroniser
`timescale 1ns/1ps
module seep_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_in,
   input  wire logic         rst_b_in,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);
   logic [W-1:0] meta_reg;

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         meta_reg <= '0;
         q_out    <= '0;
      end else begin
         meta_reg <= d_in;
         q_out    <= meta_reg;
      end
   end
endmodule : seep_sync

// ---- rtl/seep_wtimer.sv ----
// Self-timed internal write cycle timer
`timescale 1ns/1ps
module seep_wtimer #(
   parameter int CYCLES = 500000
) (
   input  wire logic       clk_in,
   input  wire logic       rst_b_in,
   input  wire logic       ce_in,
   input  wire logic       start_in,
   output logic            busy_out,
   output logic            done_out,
   output logic [19:0]     count_out
);
   localparam logic [19:0] LAST = 20'(CYCLES - 1);

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         busy_out  <= 1'b0;
         done_out  <= 1'b0;
         count_out <= 20'h0_0000;
      end else if (ce_in) begin
         done_out <= 1'b0;
         if (!busy_out && start_in) begin
            busy_out  <= 1'b1;
            count_out <= 20'h0_0000;
         end else if (busy_out) begin
            if (count_out == LAST) begin
               busy_out <= 1'b0;
               done_out <= 1'b1;
            end else begin
               count_out <= count_out + 20'h0_0001;
            end
         end
      end
   end
endmodule : seep_wtimer

// ---- rtl/seep_top.sv ----
// Serial EEPROM slave port: link logic on the serial clock, array and write cycle on the system clock
// Operation
// - Each input bit is captured on the rising serial clock edge in both clock modes.
// - Each output bit changes on the falling serial clock edge in both clock modes.
// - The serial output floats while chip select is high.
// - Deselected, the device goes to standby unless an internal write is still running.
// - Writes are allowed only while write protect is high and blocked while it is low.
// - During a pause the position within the command sequence is kept.
// - The serial output floats during a pause and is driven again when it ends.
// - The internal write finishes within 5 ms of the chip select rise ending a valid write.
// - The first byte after chip select falls is an instruction; only six opcodes act.
// - During an internal write every instruction except the status read is ignored.
`timescale 1ns/1ps
module seep_top #(
   parameter int WRITE_CYC = seep_pkg::WRITE_CYCLES
) (
   // System clock and control
   input  wire logic SYS_CLK_IN,
   input  wire logic RST_B_IN,
   input  wire logic CE_IN,
   // Serial link pins
   input  wire logic SCK_IN,
   input  wire logic CS_B_IN,
   input  wire logic SI_IN,
   input  wire logic HOLD_B_IN,
   input  wire logic WP_B_IN,
   output logic      SO_OUT,
   output logic      SO_OE_OUT,
   // Status
   output logic      STANDBY_OUT,
   output logic      BUSY_OUT
);
   import seep_pkg::*;

   // ****************************************
   // Shared storage
   // ****************************************
   logic [7:0]            mem [MEM_DEPTH];
   logic [7:0]            page_buf [PAGE_BYTES];
   logic [PAGE_BYTES-1:0] page_mask_reg;
   logic [ADDR_W-1:0]     addr_reg;
   logic [ADDR_W-1:0]     wr_addr_reg;
   logic [7:0]            sr_data_reg;
   seep_kind_t            commit_reg;

   // ****************************************
   // Link domain (serial clock)
   // ****************************************
   logic        link_rst_b;
   logic        link_en;
   logic [3:0]  stat_l;
   seep_phase_t phase_reg;
   seep_kind_t  kind_reg;
   logic [2:0]  bit_cnt_reg;
   logic [6:0]  in_sh_reg;
   logic [7:0]  byte_in;
   logic        byte_end;
   logic [7:0]  out_sh_reg;
   logic        out_en_reg;
   logic [7:0]  status_byte;
   logic [7:0]  load_byte;
   logic        busy_l;
   logic [3:0]  stat_sys;

   // frame reset
   // Counters and phase restart whenever the chip is deselected
   assign link_rst_b = RST_B_IN & ~CS_B_IN;
   // pause freeze
   // A pause simply masks serial clock edges, so all link state except the stat_l synchroniser holds
   assign link_en  = HOLD_B_IN;
   assign byte_in  = {in_sh_reg, SI_IN};
   assign byte_end = (bit_cnt_reg == 3'h7);
   assign busy_l   = stat_l[STAT_RDY_POS];

   seep_sync #(
      .W (4)
   ) u_stat_sync (
      .clk_in   (SCK_IN),
      .rst_b_in (RST_B_IN),
      .d_in     (stat_sys),
      .q_out    (stat_l)
   );

   always_ff @(posedge SCK_IN or negedge link_rst_b) begin
      if (!link_rst_b) begin
         bit_cnt_reg <= 3'h0;
         in_sh_reg   <= 7'h00;
      end else if (link_en) begin
         bit_cnt_reg <= bit_cnt_reg + 3'h1;
         in_sh_reg   <= byte_in[6:0];
      end
   end

   always_ff @(posedge SCK_IN or negedge link_rst_b) begin
      if (!link_rst_b) begin
         phase_reg <= PH_CMD;
         kind_reg  <= CK_NONE;
      end else if (link_en && byte_end) begin
         case (phase_reg)
            PH_CMD: begin
               phase_reg <= PH_IGN;
               kind_reg  <= CK_NONE;
               if (byte_in == OP_STAT_READ) begin
                  phase_reg <= PH_DATA;
                  kind_reg  <= CK_STAT;
               end else if (!busy_l) begin
                  if ((byte_in & OP_READ_MASK) == OP_READ) begin
                     phase_reg <= PH_ADDR;
                     kind_reg  <= CK_READ;
                  end else if ((byte_in & OP_READ_MASK) == OP_WRITE) begin
                     phase_reg <= PH_ADDR;
                     kind_reg  <= CK_WRITE;
                  end else if (byte_in == OP_WRSR) begin
                     phase_reg <= PH_DATA;
                     kind_reg  <= CK_WRSR;
                  end else if (byte_in == OP_WREN) begin
                     kind_reg  <= CK_WREN;
                  end else if (byte_in == OP_WRDI) begin
                     kind_reg  <= CK_WRDI;
                  end
               end
            end
            PH_ADDR: phase_reg <= PH_DATA;
            PH_DATA: phase_reg <= PH_DATA;
            PH_IGN:  phase_reg <= PH_IGN;
            default: phase_reg <= PH_IGN;
         endcase
      end
   end

   // Address, page buffer and write-status data survive the frame end
   always_ff @(posedge SCK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         addr_reg      <= '0;
         wr_addr_reg   <= '0;
         sr_data_reg   <= 8'h00;
         page_mask_reg <= '0;
      end else if (!CS_B_IN && link_en && byte_end) begin
         if (phase_reg == PH_CMD) begin
            addr_reg[ADDR_W-1] <= byte_in[3];
            page_mask_reg      <= '0;
         end else if (phase_reg == PH_ADDR) begin
            addr_reg[7:0] <= byte_in;
            wr_addr_reg   <= {addr_reg[ADDR_W-1], byte_in};
         end else if (phase_reg == PH_DATA && kind_reg == CK_READ) begin
            addr_reg <= addr_reg + 9'h001;
         end else if (phase_reg == PH_DATA && kind_reg == CK_WRITE) begin
            // Low address bits roll over inside the page
            page_mask_reg[addr_reg[PAGE_W-1:0]] <= 1'b1;
            addr_reg[PAGE_W-1:0]                <= addr_reg[PAGE_W-1:0] + 4'h1;
         end else if (phase_reg == PH_DATA && kind_reg == CK_WRSR) begin
            sr_data_reg <= byte_in;
         end
      end
   end

   always_ff @(posedge SCK_IN) begin
      if (!CS_B_IN && link_en && byte_end && phase_reg == PH_DATA && kind_reg == CK_WRITE) begin
         page_buf[addr_reg[PAGE_W-1:0]] <= byte_in;
      end
   end

   // Frame outcome: valid only when the frame ends on a byte boundary
   always_ff @(posedge SCK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         commit_reg <= CK_NONE;
      end else if (!CS_B_IN && link_en) begin
         if (phase_reg == PH_CMD && bit_cnt_reg == 3'h0) begin
            commit_reg <= CK_NONE;
         end else if (phase_reg == PH_CMD && byte_end && !busy_l &&
                      (byte_in == OP_WREN || byte_in == OP_WRDI)) begin
            commit_reg <= (byte_in == OP_WREN) ? CK_WREN : CK_WRDI;
         end else if (phase_reg == PH_IGN) begin
            commit_reg <= CK_NONE;
         end else if (phase_reg == PH_DATA && (kind_reg == CK_WRITE || kind_reg == CK_WRSR)) begin
            commit_reg <= byte_end ? kind_reg : CK_NONE;
         end
      end
   end

   assign status_byte = busy_l ? STAT_BUSY : {STAT_FIXED, stat_l[STAT_BP_HI:STAT_BP_LO],
                                              stat_l[STAT_WEL_POS], 1'b0};
   assign load_byte   = (kind_reg == CK_STAT) ? status_byte : mem[addr_reg];

   always_ff @(negedge SCK_IN or negedge link_rst_b) begin
      if (!link_rst_b) begin
         out_sh_reg <= 8'h00;
         out_en_reg <= 1'b0;
      end else if (link_en) begin
         if (phase_reg == PH_DATA && bit_cnt_reg == 3'h0 &&
             (kind_reg == CK_READ || kind_reg == CK_STAT)) begin
            out_sh_reg <= load_byte;
            out_en_reg <= 1'b1;
         end else begin
            out_sh_reg <= {out_sh_reg[6:0], 1'b0};
         end
      end
   end

   assign SO_OUT = out_sh_reg[7];
   assign SO_OE_OUT = ~CS_B_IN & HOLD_B_IN & out_en_reg;

   // ****************************************
   // System domain
   // ****************************************
   logic              cs_sel_s;
   logic              cs_b_s;
   logic              wp_b_s;
   logic              cs_b_d_reg;
   logic              cs_rise;
   logic              start;
   logic              wr_busy;
   logic              wr_done;
   logic [19:0]       wr_count;
   logic              wel_reg;
   logic [1:0]        bp_reg;
   logic              arr_job_reg;
   logic [ADDR_W-1:0] wr_loc;
   logic              prot;
   logic              wr_ok;

   seep_sync #(
      .W (2)
   ) u_pin_sync (
      .clk_in   (SYS_CLK_IN),
      .rst_b_in (RST_B_IN),
      .d_in     ({~CS_B_IN, WP_B_IN}),
      .q_out    ({cs_sel_s, wp_b_s})
   );

   // Select synchronised active high so its reset level is the idle level: no false rise
   assign cs_b_s = ~cs_sel_s;

   always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         cs_b_d_reg <= 1'b1;
      end else if (CE_IN) begin
         cs_b_d_reg <= cs_b_s;
      end
   end

   assign cs_rise = cs_b_s & ~cs_b_d_reg;
   assign wr_ok   = wel_reg & wp_b_s & ~wr_busy;
   assign start   = CE_IN & cs_rise & wr_ok & (commit_reg == CK_WRITE || commit_reg == CK_WRSR);

   seep_wtimer #(
      .CYCLES (WRITE_CYC)
   ) u_wtimer (
      .clk_in    (SYS_CLK_IN),
      .rst_b_in  (RST_B_IN),
      .ce_in     (CE_IN),
      .start_in  (start),
      .busy_out  (wr_busy),
      .done_out  (wr_done),
      .count_out (wr_count)
   );

   // Latch enable, block protect and job type
   always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         wel_reg     <= 1'b0;
         bp_reg      <= BP_RESET;
         arr_job_reg <= 1'b0;
      end else if (CE_IN) begin
         if (wr_done) begin
            wel_reg <= 1'b0;
         end else if (cs_rise && !wr_busy) begin
            if (commit_reg == CK_WREN) begin
               wel_reg <= 1'b1;
            end else if (commit_reg == CK_WRDI) begin
               wel_reg <= 1'b0;
            end
         end
         if (start) begin
            arr_job_reg <= (commit_reg == CK_WRITE);
            if (commit_reg == CK_WRSR) begin
               bp_reg <= sr_data_reg[STAT_BP_HI:STAT_BP_LO];
            end
         end
      end
   end

   // One page byte per cycle at the start of the write cycle
   assign wr_loc = {wr_addr_reg[ADDR_W-1:PAGE_W], wr_count[PAGE_W-1:0]};
   always_comb begin
      case (bp_reg)
         2'h1:    prot = (wr_loc >= QUARTER_BASE);
         2'h2:    prot = (wr_loc >= HALF_BASE);
         2'h3:    prot = 1'b1;
         default: prot = 1'b0;
      endcase
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (CE_IN && wr_busy && arr_job_reg && wr_count < 20'(PAGE_BYTES) &&
          page_mask_reg[wr_count[PAGE_W-1:0]] && !prot) begin
         mem[wr_loc] <= page_buf[wr_count[PAGE_W-1:0]];
      end
   end

   assign stat_sys = {bp_reg, wel_reg, wr_busy};

   assign STANDBY_OUT = cs_b_s & ~wr_busy;
   assign BUSY_OUT    = wr_busy;

endmodule : seep_top

// ---- tb/seep_assertions.sv ----
// Port-level checker of the serial EEPROM slave port
`timescale 1ns/1ps
module seep_assertions #(
   parameter int WRITE_CYC = 40
) (
   // Clock and control
   input wire logic SYS_CLK_IN,
   input wire logic RST_B_IN,
   input wire logic CE_IN,
   // Link pins
   input wire logic SCK_IN,
   input wire logic CS_B_IN,
   input wire logic HOLD_B_IN,
   input wire logic WP_B_IN,
   input wire logic SO_OUT,
   input wire logic SO_OE_OUT,
   // Status
   input wire logic STANDBY_OUT,
   input wire logic BUSY_OUT
);
   logic [19:0] busy_cnt_reg;
   default clocking cb @(posedge SYS_CLK_IN); endclocking
   default disable iff (!RST_B_IN);
   // Enabled cycles of the current write cycle
   always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) busy_cnt_reg <= 20'h0_0000;
      else if (!BUSY_OUT) busy_cnt_reg <= 20'h0_0000;
      else if (CE_IN) busy_cnt_reg <= busy_cnt_reg + 20'h0_0001;
   end
   sequence cs_idle;
      CS_B_IN [*4];
   endsequence
   sequence cs_active;
      !CS_B_IN [*4];
   endsequence
   a_cs_float:
      assert property (CS_B_IN |-> !SO_OE_OUT) else $error("SO driven while deselected");
   a_hold_float:
      assert property (!HOLD_B_IN |-> !SO_OE_OUT) else $error("SO driven during pause");
   a_so_steady:
      assert property ((SCK_IN && $past(SCK_IN) && SO_OE_OUT && $past(SO_OE_OUT)) |-> $stable(SO_OUT))
         else $error("SO changed while serial clock high");
   a_busy_length:
      assert property ($fell(BUSY_OUT) |-> busy_cnt_reg == 20'(WRITE_CYC)) else $error("write cycle length wrong");
   a_busy_no_standby:
      assert property (BUSY_OUT |-> !STANDBY_OUT) else $error("standby during write cycle");
   a_idle_standby:
      assert property (cs_idle ##0 !BUSY_OUT |-> STANDBY_OUT) else $error("no standby when idle");
   a_active_awake:
      assert property (cs_active |-> !STANDBY_OUT) else $error("standby while selected");
   a_busy_wp:
      assert property ($rose(BUSY_OUT) |-> $past(WP_B_IN, 3)) else $error("write started while protected");
   a_busy_after_cs:
      assert property ($rose(BUSY_OUT) |-> CS_B_IN && $past(CS_B_IN, 2)) else $error("write began before deselect");
endmodule : seep_assertions
bind seep_top seep_assertions #(.WRITE_CYC(WRITE_CYC)) chk_u (.SYS_CLK_IN(SYS_CLK_IN), .RST_B_IN(RST_B_IN),
   .CE_IN(CE_IN), .SCK_IN(SCK_IN), .CS_B_IN(CS_B_IN), .HOLD_B_IN(HOLD_B_IN), .WP_B_IN(WP_B_IN),
   .SO_OUT(SO_OUT), .SO_OE_OUT(SO_OE_OUT), .STANDBY_OUT(STANDBY_OUT), .BUSY_OUT(BUSY_OUT));

// ---- tb/seep_host.sv ----
// SPI host model driving the serial link pins
`timescale 1ns/1ps
module seep_host (
   // Link pins driven
   output logic      sck_out    = 1'b0,
   output logic      cs_b_out   = 1'b1,
   output logic      si_out     = 1'b0,
   output logic      hold_b_out = 1'b1,
   // Link pins seen
   input  wire logic so_in,
   input  wire logic so_oe_in
);
   // select falls to open a frame
   task automatic open_frame(input logic cpol);
      sck_out  = cpol;
      #40;
      cs_b_out = 1'b0;
      #40;
   endtask : open_frame
   // select rises to close, data line toggled
   task automatic close_frame(input logic cpol);
      #15;
      sck_out  = cpol;
      #40;
      cs_b_out = 1'b1;
      si_out   = ~si_out;
      #100;
   endtask : close_frame
   task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 0; i < n; i++) begin
         sck_out = 1'b0;
         si_out  = tx[7-i];
         #15;
         sck_out = 1'b1;
         // Released line reads as pulled up
         rx[7-i] = so_oe_in ? so_in : 1'b1;
         #15;
      end
   endtask : shift
   // pause edges only with clock low
   task automatic pause(output logic oe);
      sck_out    = 1'b0;
      #15;
      hold_b_out = 1'b0;
      #10;
      oe         = so_oe_in;
      repeat (3) begin
         si_out  = ~si_out;
         sck_out = 1'b1;
         #15;
         sck_out = 1'b0;
         #15;
      end
      hold_b_out = 1'b1;
      #10;
   endtask : pause
endmodule : seep_host

// ---- tb/seep_top_tb.sv ----
// Self-checking bench of the serial EEPROM slave port
`timescale 1ns/1ps
module seep_top_tb;
   import seep_pkg::*;
   localparam int WCYC = 400;
   logic       sys_clk = 1'b0;
   logic       rst_b   = 1'b0;
   logic       ce      = 1'b1;
   logic       wp_b    = 1'b1;
   logic       sck, cs_b, si, hold_b, so, so_oe, standby, busy, o;
   logic [7:0] s;
   int         mismatches = 0;
   int         tests_run  = 0;
   always #5 sys_clk = ~sys_clk;
   seep_top #(.WRITE_CYC(WCYC)) dut_u (.SYS_CLK_IN(sys_clk), .RST_B_IN(rst_b), .CE_IN(ce), .SCK_IN(sck),
      .CS_B_IN(cs_b), .SI_IN(si), .HOLD_B_IN(hold_b), .WP_B_IN(wp_b), .SO_OUT(so), .SO_OE_OUT(so_oe),
      .STANDBY_OUT(standby), .BUSY_OUT(busy));
   seep_host host_u (.sck_out(sck), .cs_b_out(cs_b), .si_out(si), .hold_b_out(hold_b), .so_in(so),
      .so_oe_in(so_oe));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic tally_and_finish();
      $display("mismatches %0d tests_run %0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : tally_and_finish
   // One framed transfer; optional pause inside the last byte
   task automatic frame(input logic cpol, input logic pz, input logic [7:0] op, input logic [7:0] a,
                        input logic [7:0] d, input int n);
      logic [7:0] b [3];
      logic [7:0] r1, r2;
      b = '{op, a, d};
      o = 1'b0;
      host_u.open_frame(cpol);
      for (int k = 0; k <= n; k++) begin
         if (pz && k == n) begin
            host_u.shift(b[k], 4, r1);
            host_u.pause(o);
            host_u.shift(b[k] << 4, 4, r2);
            s = {r1[7:4], r2[7:4]};
         end else begin
            host_u.shift(b[k], 8, s);
         end
      end
      host_u.close_frame(cpol);
   endtask : frame
   task automatic wait_busy(input logic v);
      for (int k = 0; k < WCYC + 40 && busy !== v; k++) begin
         @(posedge sys_clk);
         #1;
      end
      if (busy !== v) begin
         check({7'h00, busy}, {7'h00, v});
         tally_and_finish();
      end
   endtask : wait_busy
   task automatic t_reset();
      check({5'h00, standby, so_oe, busy}, 8'h04);
   endtask : t_reset
   task automatic t_opcodes();
      for (int c = 0; c < 2; c++) begin
         frame(c[0], 1'b0, OP_STAT_READ, 8'h00, 8'h00, 1);
         check(s, 8'hF0);
         frame(c[0], 1'b0, OP_WREN | 8'h08, 8'h00, 8'h00, 0);
         frame(c[0], 1'b0, OP_STAT_READ, 8'h00, 8'h00, 1);
         check(s, 8'hF0);
         frame(~c[0], 1'b0, OP_WREN, 8'h00, 8'h00, 0);
         frame(c[0], 1'b0, OP_STAT_READ, 8'h00, 8'h00, 1);
         check(s, 8'hF2);
         frame(c[0], 1'b0, OP_WRDI, 8'h00, 8'h00, 0);
         frame(~c[0], 1'b0, OP_STAT_READ, 8'h00, 8'h00, 1);
         check(s, 8'hF0);
      end
   endtask : t_opcodes
   task automatic t_wp_block();
      @(posedge sys_clk);
      wp_b <= 1'b0;
      frame(1'b0, 1'b0, OP_WREN, 8'h00, 8'h00, 0);
      frame(1'b0, 1'b0, OP_WRITE, 8'h10, 8'h3C, 2);
      repeat (20) @(posedge sys_clk);
      check({7'h00, busy}, 8'h00);
      frame(1'b0, 1'b0, OP_STAT_READ, 8'h00, 8'h00, 1);
      check(s, 8'hF2);
      @(posedge sys_clk);
      wp_b <= 1'b1;
      repeat (10) @(posedge sys_clk);
   endtask : t_wp_block
   task automatic t_write_read();
      frame(1'b1, 1'b1, OP_WRITE | 8'h08, 8'h34, 8'hA5, 2);
      wait_busy(1'b1);
      check({6'h00, standby, busy}, 8'h01);
      frame(1'b0, 1'b0, OP_STAT_READ, 8'h00, 8'h00, 1);
      check(s, 8'hFF);
      frame(1'b0, 1'b0, OP_READ | 8'h08, 8'h34, 8'h00, 2);
      check(s, 8'hFF);
      frame(1'b0, 1'b0, OP_WREN, 8'h00, 8'h00, 0);
      @(posedge sys_clk);
      ce <= 1'b0;
      repeat (5) @(posedge sys_clk);
      ce <= 1'b1;
      wait_busy(1'b0);
      frame(1'b1, 1'b0, OP_STAT_READ, 8'h00, 8'h00, 1);
      check(s, 8'hF0);
      frame(1'b1, 1'b1, OP_READ | 8'h08, 8'h34, 8'h00, 2);
      check(s, 8'hA5);
      check({7'h00, o}, 8'h00);
   endtask : t_write_read
   task automatic t_wrsr();
      frame(1'b0, 1'b0, OP_WREN, 8'h00, 8'h00, 0);
      frame(1'b0, 1'b0, OP_WRSR, 8'h0C, 8'h00, 1);
      wait_busy(1'b1);
      wait_busy(1'b0);
      frame(1'b0, 1'b0, OP_STAT_READ, 8'h00, 8'h00, 1);
      check(s, 8'hFC);
      frame(1'b0, 1'b0, OP_WREN, 8'h00, 8'h00, 0);
      frame(1'b0, 1'b0, OP_WRITE | 8'h08, 8'h34, 8'h5A, 2);
      wait_busy(1'b1);
      wait_busy(1'b0);
      frame(1'b0, 1'b0, OP_READ | 8'h08, 8'h34, 8'h00, 2);
      check(s, 8'hA5);
   endtask : t_wrsr
   initial begin
      repeat (16) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (5) @(posedge sys_clk);
      t_reset();
      t_opcodes();
      t_wp_block();
      t_write_read();
      t_wrsr();
      tally_and_finish();
   end
endmodule : seep_top_tb
